// ---- include/fscl_regs.vh ----
// Constants for the filter/shutter command link.
// Assumes a single 25 MHz system clock; included by bare name.
`ifndef FSCL_REGS_VH
`define FSCL_REGS_VH

// ----------------------------------------
// Clock and serial timing
// ----------------------------------------
`define FSCL_CLK_HZ 25000000
`define FSCL_BAUD_9600 9600
`define FSCL_BAUD_19200 19200
`define FSCL_BAUD_115200 115200
`define FSCL_BAUD_128000 128000
`define FSCL_DIV_9600 (`FSCL_CLK_HZ / `FSCL_BAUD_9600)
`define FSCL_DIV_19200 (`FSCL_CLK_HZ / `FSCL_BAUD_19200)
`define FSCL_DIV_115200 (`FSCL_CLK_HZ / `FSCL_BAUD_115200)
`define FSCL_DIV_128000 (`FSCL_CLK_HZ / `FSCL_BAUD_128000)
`define FSCL_DIV_W 12

// ----------------------------------------
// Baud select codes
// ----------------------------------------
`define FSCL_SEL_9600 2'h0
`define FSCL_SEL_19200 2'h1
`define FSCL_SEL_115200 2'h2
`define FSCL_SEL_128000 2'h3

// ----------------------------------------
// Protocol values
// ----------------------------------------
`define FSCL_COMPLETE_BYTE 8'h0D
`define FSCL_TX_IDLE_BIT 1'b1

// ----------------------------------------
// Command FSM state codes
// ----------------------------------------
`define FSCL_ST_CMD 3'h0
`define FSCL_ST_LEN 3'h1
`define FSCL_ST_PARAM 3'h2
`define FSCL_ST_ECHOW 3'h3
`define FSCL_ST_EXEC 3'h4
`define FSCL_ST_DONE 3'h5

`endif

// ---- tb/fscl_cmd_link_props.sv ----
// Checker for the command link: echo, reply and shutter paths.
// Assumes it sees only the top module's ports through bind.
`timescale 1ns/1ps
`default_nettype none
module fscl_cmd_link_props (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic serial_tx_out,
  input wire logic cmd_valid_out,
  input wire logic op_start_out,
  input wire logic op_done_in,
  input wire logic rx_dropped_out,
  input wire logic frame_err_out,
  input wire logic shutter_ext_enable_in,
  input wire logic shutter_a_logic_input_in,
  input wire logic shutter_b_logic_input_in,
  input wire logic shutter_ext_active_out,
  input wire logic shutter_a_open_out,
  input wire logic shutter_b_open_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // Settle count, so sync history is from after reset
  logic [2:0] up_r;
  always @(posedge clock_in) begin
    if (!rst_n_in) up_r <= 3'h0;
    else if (up_r != 3'h7) up_r <= up_r + 3'h1;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  shut_a_follow_a: assert property (up_r == 3'h7 |-> shutter_a_open_out ==
    ($past(shutter_ext_enable_in) && $past(shutter_a_logic_input_in, 3))) else $error("open a");
  shut_b_follow_a: assert property (up_r == 3'h7 |-> shutter_b_open_out ==
    ($past(shutter_ext_enable_in) && $past(shutter_b_logic_input_in, 3))) else $error("open b");
  ext_gate_a: assert property (!shutter_ext_active_out |->
    !shutter_a_open_out && !shutter_b_open_out) else $error("gate");
  // Echo start bit lands one cycle after the command pulse
  cmd_echo_a: assert property (cmd_valid_out |=>
    !serial_tx_out && $past(serial_tx_out)) else $error("echo start");
  start_after_echo_a: assert property (op_start_out |->
    serial_tx_out && $past(serial_tx_out)) else $error("start early");
  no_early_reply_a: assert property ((op_start_out && !op_done_in ##1 !op_done_in [*2]) |=>
    serial_tx_out) else $error("reply early");
  done_reply_a: assert property ($rose(op_done_in) |-> ##[1:3] !serial_tx_out)
    else $error("reply late");
  drop_silent_a: assert property (rx_dropped_out |-> ##1 serial_tx_out [*2])
    else $error("drop echoed");
  frame_no_echo_a: assert property (frame_err_out |-> ##1 serial_tx_out [*2])
    else $error("bad frame echoed");
endmodule
bind fscl_cmd_link fscl_cmd_link_props u_props (.clock_in(clock_in), .rst_n_in(rst_n_in),
  .serial_tx_out(serial_tx_out), .cmd_valid_out(cmd_valid_out), .op_start_out(op_start_out),
  .op_done_in(op_done_in), .rx_dropped_out(rx_dropped_out), .frame_err_out(frame_err_out),
  .shutter_ext_enable_in(shutter_ext_enable_in),
  .shutter_a_logic_input_in(shutter_a_logic_input_in),
  .shutter_b_logic_input_in(shutter_b_logic_input_in),
  .shutter_ext_active_out(shutter_ext_active_out),
  .shutter_a_open_out(shutter_a_open_out), .shutter_b_open_out(shutter_b_open_out));
`default_nettype wire

// ---- tb/fscl_host.sv ----
// Host model: byte sender and receiver of echoes and replies.
// Assumes div_in holds the bit time in clocks, steady per frame.
`timescale 1ns/1ps
`default_nettype none
module fscl_host (
  input wire logic clock_in,
  input wire logic [11:0] div_in,
  input wire logic line_in,
  output logic line_out
);
  logic [7:0] rq[$];
  initial line_out = 1'b1;
  // raw byte, 8N1, LSB first; a low stop makes a bad frame
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (div_in) @(posedge clock_in);
    end
  endtask
  // Idle line, needed after a bad frame leaves it low
  task automatic rest(input int n);
    line_out <= 1'b1;
    repeat (n) @(posedge clock_in);
  endtask
  initial forever begin : rx
    logic [7:0] d;
    @(negedge line_in);
    repeat (div_in / 2) @(posedge clock_in);
    for (int i = 0; i < 8; i++) begin
      repeat (div_in) @(posedge clock_in);
      d[i] = line_in;
    end
    repeat (div_in) @(posedge clock_in);
    rq.push_back(d);
  end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Bench for the command link: shutter paths, then command sequences.
// Assumes the host model in fscl_host and a 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, rst_n = 0, rx, en = 0, pa = 0, pb = 0, done = 0;
  logic [1:0] bsel = 2'h0;
  logic [3:0] pcnt = 4'h0;
  logic [11:0] hdiv = 12'h0c3;
  logic tx, cv, pv, os, dr, fe, act, ao, bo;
  logic [7:0] cb, pbo;
  logic [7:0] pq[$];
  int seed = 32'hf84a_ba0e, err_count = 0, cmp_count = 0, drops = 0, ferrs = 0, cyc = 0;
  always #20 clk = ~clk;
  fscl_cmd_link uut (.clock_in(clk), .rst_n_in(rst_n), .baud_sel_in(bsel),
    .serial_rx_in(rx), .serial_tx_out(tx), .param_count_in(pcnt), .cmd_byte_out(cb),
    .cmd_valid_out(cv), .param_byte_out(pbo), .param_valid_out(pv), .op_start_out(os),
    .op_done_in(done), .rx_dropped_out(dr), .frame_err_out(fe),
    .shutter_ext_enable_in(en), .shutter_a_logic_input_in(pa),
    .shutter_b_logic_input_in(pb), .shutter_ext_active_out(act),
    .shutter_a_open_out(ao), .shutter_b_open_out(bo));
  fscl_host host (.clock_in(clk), .div_in(hdiv), .line_in(tx), .line_out(rx));
  task automatic end_of_test;
    $display("compared %0d, mismatched %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Pulse capture off the edge; hang limit
  always @(negedge clk) begin
    if (pv === 1'b1) pq.push_back(pbo);
    if (dr === 1'b1) drops++;
    if (fe === 1'b1) ferrs++;
    cyc++;
    if (cyc == 100000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic shut(input logic e, input logic a, input logic b);
    @(posedge clk);
    en <= e;
    pa <= a;
    pb <= b;
    repeat (4) @(posedge clk);
    #1;
    chk("active", {7'h00, e}, {7'h00, act});
    chk("open_a", {7'h00, e & a}, {7'h00, ao});
    chk("open_b", {7'h00, e & b}, {7'h00, bo});
  endtask
  task automatic seq(input logic [1:0] s, input int k);
    logic [7:0] c;
    logic [7:0] p[$];
    int n;
    @(posedge clk);
    bsel <= s;
    pcnt <= k[3:0];
    hdiv = (s == 2'h2) ? 12'h0d9 : 12'h0c3;
    repeat (2) @(posedge clk);
    pq.delete();
    host.rq.delete();
    drops = 0;
    ferrs = 0;
    // Bad stop bit: no echo, sequence state kept
    host.send(8'h00, 1'b0);
    host.rest(2 * hdiv);
    c = 8'($random(seed));
    host.send(c, 1'b1);
    for (int i = 0; i < k; i++) begin
      p.push_back(8'($random(seed)));
      host.send(p[i], 1'b1);
    end
    n = 0;
    while (os !== 1'b1 && n < 30000) begin
      @(negedge clk);
      n++;
    end
    chk("op_start", 8'h01, {7'h00, os});
    // Stray byte while the operation runs
    @(posedge clk);
    host.send(8'h5a, 1'b1);
    repeat (8) @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    n = 0;
    while (host.rq.size() < k + 2 && n < 30000) begin
      @(posedge clk);
      n++;
    end
    repeat (hdiv) @(posedge clk);
    chk("replies", 8'(k + 2), 8'(host.rq.size()));
    chk("frame_err", 8'h01, ferrs[7:0]);
    chk("cmd_byte", c, cb);
    chk("echo_cmd", c, host.rq[0]);
    for (int i = 0; i < k; i++) begin
      chk("echo_param", p[i], host.rq[i + 1]);
      chk("param_byte", p[i], pq[i]);
    end
    chk("reply", 8'h0d, host.rq[k + 1]);
    chk("dropped", 8'h01, drops[7:0]);
    $display("test sequence done");
  endtask
  initial begin
    int r;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int v = 0; v < 8; v += 2) begin
      shut(1'b1, ~v[1], v[2]);
    end
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      shut(r[0], r[1], r[2]);
    end
    $display("test shutter done");
    seq(2'h2, {$random(seed)} % 4);
    seq(2'h3, 0);
    seq(2'h3, 3);
    end_of_test();
  end
endmodule
`default_nettype wire

// ---- verilog/fscl_cmd_link.v ----
// Command reception, echo and completion reply, plus logic-level shutter inputs.
// Assumes an outside decoder gives the parameter count for the held command byte
// and answers each operation start with one done pulse.
`timescale 1ns/1ps
`default_nettype none
`include "fscl_regs.vh"

module fscl_cmd_link (
  input wire clock_in,
  input wire rst_n_in,
  input wire [1:0] baud_sel_in,
  input wire serial_rx_in,
  output wire serial_tx_out,
  input wire [3:0] param_count_in,
  output wire [7:0] cmd_byte_out,
  output wire cmd_valid_out,
  output wire [7:0] param_byte_out,
  output wire param_valid_out,
  output wire op_start_out,
  input wire op_done_in,
  output wire rx_dropped_out,
  output wire frame_err_out,
  input wire shutter_ext_enable_in,
  input wire shutter_a_logic_input_in,
  input wire shutter_b_logic_input_in,
  output wire shutter_ext_active_out,
  output wire shutter_a_open_out,
  output wire shutter_b_open_out
);

  // ----------------------------------------
  // Bit timing
  // ----------------------------------------
  localparam [31:0] DIV_9600 = `FSCL_DIV_9600;
  localparam [31:0] DIV_19200 = `FSCL_DIV_19200;
  localparam [31:0] DIV_115200 = `FSCL_DIV_115200;
  localparam [31:0] DIV_128000 = `FSCL_DIV_128000;

  reg [`FSCL_DIV_W-1:0] bit_div_r;
  reg [`FSCL_DIV_W-1:0] bit_div_nxt;

  always @* begin
    case (baud_sel_in)
      `FSCL_SEL_19200: bit_div_nxt = DIV_19200[`FSCL_DIV_W-1:0];
      `FSCL_SEL_115200: bit_div_nxt = DIV_115200[`FSCL_DIV_W-1:0];
      `FSCL_SEL_128000: bit_div_nxt = DIV_128000[`FSCL_DIV_W-1:0];
      default: bit_div_nxt = DIV_9600[`FSCL_DIV_W-1:0];
    endcase
  end

  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      bit_div_r <= DIV_9600[`FSCL_DIV_W-1:0];
    end else begin
      bit_div_r <= bit_div_nxt;
    end
  end

  // ----------------------------------------
  // Serial port
  // ----------------------------------------
  wire [7:0] rx_data;
  wire rx_valid;
  wire tx_ready;
  wire tx_start;
  wire [7:0] tx_data;

  fscl_uart u_uart (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .bit_div_in(bit_div_r),
    .rx_pin_in(serial_rx_in),
    .rx_data_out(rx_data),
    .rx_valid_out(rx_valid),
    .rx_frame_err_out(frame_err_out),
    .tx_data_in(tx_data),
    .tx_start_in(tx_start),
    .tx_ready_out(tx_ready),
    .tx_pin_out(serial_tx_out)
  );

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  reg [2:0] state_r;
  reg [3:0] left_r;
  reg [7:0] cmd_r;
  reg cmd_valid_r;
  reg [7:0] param_r;
  reg param_valid_r;
  reg [7:0] echo_r;
  reg echo_pend_r;
  reg op_start_r;
  reg dropped_r;

  wire in_seq = (state_r == `FSCL_ST_CMD) || (state_r == `FSCL_ST_PARAM);
  wire accept = rx_valid && in_seq;
  wire done_state = (state_r == `FSCL_ST_DONE);

  // echo leaves as soon as the line is free
  assign tx_start = tx_ready && (echo_pend_r || done_state);
  assign tx_data = done_state ? `FSCL_COMPLETE_BYTE : echo_r;

  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_r <= `FSCL_ST_CMD;
      left_r <= 4'h0;
      cmd_r <= 8'h00;
      cmd_valid_r <= 1'b0;
      param_r <= 8'h00;
      param_valid_r <= 1'b0;
      echo_r <= 8'h00;
      echo_pend_r <= 1'b0;
      op_start_r <= 1'b0;
      dropped_r <= 1'b0;
    end else begin
      cmd_valid_r <= 1'b0;
      param_valid_r <= 1'b0;
      op_start_r <= 1'b0;
      // Bytes outside a sequence have nowhere to go
      dropped_r <= rx_valid && !in_seq;
      // new byte wins over the clear
      if (accept) begin
        echo_r <= rx_data;
        echo_pend_r <= 1'b1;
      end else if (tx_start && !done_state) begin
        echo_pend_r <= 1'b0;
      end
      case (state_r)
        `FSCL_ST_CMD: begin
          if (rx_valid) begin
            cmd_r <= rx_data;
            cmd_valid_r <= 1'b1;
            state_r <= `FSCL_ST_LEN;
          end
        end
        `FSCL_ST_LEN: begin
          left_r <= param_count_in;
          if (param_count_in == 4'h0) begin
            state_r <= `FSCL_ST_ECHOW;
          end else begin
            state_r <= `FSCL_ST_PARAM;
          end
        end
        `FSCL_ST_PARAM: begin
          if (rx_valid) begin
            param_r <= rx_data;
            param_valid_r <= 1'b1;
            left_r <= left_r - 1'b1;
            if (left_r == 4'h1) begin
              state_r <= `FSCL_ST_ECHOW;
            end
          end
        end
        `FSCL_ST_ECHOW: begin
          // final echo fully on the wire first
          if (!echo_pend_r && tx_ready) begin
            op_start_r <= 1'b1;
            state_r <= `FSCL_ST_EXEC;
          end
        end
        `FSCL_ST_EXEC: begin
          if (op_done_in) begin
            state_r <= `FSCL_ST_DONE;
          end
        end
        `FSCL_ST_DONE: begin
          if (tx_ready) begin
            state_r <= `FSCL_ST_CMD;
          end
        end
        default: begin
          state_r <= `FSCL_ST_CMD;
        end
      endcase
    end
  end

  assign cmd_byte_out = cmd_r;
  assign cmd_valid_out = cmd_valid_r;
  assign param_byte_out = param_r;
  assign param_valid_out = param_valid_r;
  assign op_start_out = op_start_r;
  assign rx_dropped_out = dropped_r;

  // ----------------------------------------
  // Logic-level shutter inputs
  // ----------------------------------------
  wire [1:0] sh_pin = {shutter_b_logic_input_in, shutter_a_logic_input_in};
  wire [1:0] sh_open;
  reg ext_active_r;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_shutter
      reg s1_r;
      reg s2_r;
      reg open_r;
      always @(posedge clock_in) begin
        if (!rst_n_in) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          open_r <= 1'b0;
        end else begin
          s1_r <= sh_pin[gi];
          s2_r <= s1_r;
          open_r <= shutter_ext_enable_in && s2_r;
        end
      end
      assign sh_open[gi] = open_r;
    end
  endgenerate

  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      ext_active_r <= 1'b0;
    end else begin
      ext_active_r <= shutter_ext_enable_in;
    end
  end

  assign shutter_ext_active_out = ext_active_r;
  assign shutter_a_open_out = sh_open[0];
  assign shutter_b_open_out = sh_open[1];

endmodule
`default_nettype wire

// ---- verilog/fscl_uart.v ----
// Byte UART, 8 data bits, 1 stop bit, no parity, LSB first.
// Assumes bit_div_in is held steady while a frame is in flight.
`timescale 1ns/1ps
`default_nettype none
`include "fscl_regs.vh"

module fscl_uart (
  input wire clock_in,
  input wire rst_n_in,
  input wire [`FSCL_DIV_W-1:0] bit_div_in,
  input wire rx_pin_in,
  output wire [7:0] rx_data_out,
  output wire rx_valid_out,
  output wire rx_frame_err_out,
  input wire [7:0] tx_data_in,
  input wire tx_start_in,
  output wire tx_ready_out,
  output wire tx_pin_out
);

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  reg rx_s1_r;
  reg rx_s2_r;
  reg rx_busy_r;
  reg [`FSCL_DIV_W-1:0] rx_cnt_r;
  reg [3:0] rx_bit_r;
  reg [7:0] rx_shift_r;
  reg [7:0] rx_data_r;
  reg rx_valid_r;
  reg rx_ferr_r;

  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_busy_r <= 1'b0;
      rx_cnt_r <= {`FSCL_DIV_W{1'b0}};
      rx_bit_r <= 4'h0;
      rx_shift_r <= 8'h00;
      rx_data_r <= 8'h00;
      rx_valid_r <= 1'b0;
      rx_ferr_r <= 1'b0;
    end else begin
      rx_s1_r <= rx_pin_in;
      rx_s2_r <= rx_s1_r;
      rx_valid_r <= 1'b0;
      rx_ferr_r <= 1'b0;
      if (!rx_busy_r) begin
        if (!rx_s2_r) begin
          // Half a bit to land mid-cell
          rx_busy_r <= 1'b1;
          rx_cnt_r <= bit_div_in >> 1;
          rx_bit_r <= 4'h0;
        end
      end else if (rx_cnt_r != {`FSCL_DIV_W{1'b0}}) begin
        rx_cnt_r <= rx_cnt_r - 1'b1;
      end else begin
        rx_cnt_r <= bit_div_in - 1'b1;
        rx_bit_r <= rx_bit_r + 1'b1;
        if (rx_bit_r == 4'h0) begin
          // Glitch, not a start bit
          if (rx_s2_r) begin
            rx_busy_r <= 1'b0;
          end
        end else if (rx_bit_r <= 4'h8) begin
          rx_shift_r <= {rx_s2_r, rx_shift_r[7:1]};
        end else begin
          rx_busy_r <= 1'b0;
          if (rx_s2_r) begin
            rx_data_r <= rx_shift_r;
            rx_valid_r <= 1'b1;
          end else begin
            rx_ferr_r <= 1'b1;
          end
        end
      end
    end
  end

  assign rx_data_out = rx_data_r;
  assign rx_valid_out = rx_valid_r;
  assign rx_frame_err_out = rx_ferr_r;

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  reg tx_busy_r;
  reg [`FSCL_DIV_W-1:0] tx_cnt_r;
  reg [3:0] tx_bit_r;
  reg [9:0] tx_shift_r;
  reg tx_pin_r;

  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      tx_busy_r <= 1'b0;
      tx_cnt_r <= {`FSCL_DIV_W{1'b0}};
      tx_bit_r <= 4'h0;
      tx_shift_r <= 10'h3FF;
      tx_pin_r <= `FSCL_TX_IDLE_BIT;
    end else if (!tx_busy_r) begin
      if (tx_start_in) begin
        tx_busy_r <= 1'b1;
        tx_cnt_r <= bit_div_in - 1'b1;
        tx_bit_r <= 4'h0;
        tx_shift_r <= {1'b1, tx_data_in, 1'b0};
        tx_pin_r <= 1'b0;
      end
    end else if (tx_cnt_r != {`FSCL_DIV_W{1'b0}}) begin
      tx_cnt_r <= tx_cnt_r - 1'b1;
    end else begin
      tx_cnt_r <= bit_div_in - 1'b1;
      tx_bit_r <= tx_bit_r + 1'b1;
      tx_shift_r <= {1'b1, tx_shift_r[9:1]};
      tx_pin_r <= tx_shift_r[1];
      if (tx_bit_r == 4'h9) begin
        tx_busy_r <= 1'b0;
        tx_pin_r <= `FSCL_TX_IDLE_BIT;
      end
    end
  end

  assign tx_ready_out = !tx_busy_r;
  assign tx_pin_out = tx_pin_r;

endmodule
`default_nettype wire
